// ===== core/output_gating.v
`timescale 1ns/100ps
`default_nettype none
`include "clkgen_defines.vh"

// output gating and pll0 multiplier configuration
module output_gating (
    input  wire        clk,
    input  wire        resetn,
    // register port from the serial programming decoder
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    output reg         reg_hit,
    // config slot 0 multiplier byte lives in the neighbouring range
    input  wire [7:0]  cfg0_multiplier_byte,
    input  wire [7:0]  feedback_low,
    input  wire [1:0]  config_select,
    input  wire        spread_spectrum_en,
    // switch matrix and style settings from neighbouring registers
    input  wire [11:0] output_pll_source,
    input  wire [11:0] output_disable_style,
    input  wire        multi_function_pin_mode,
    // asynchronous device pins
    input  wire        shutdown_pin,
    input  wire        suspend_input_pin,
    // results
    output reg  [13:0] pll0_total_multiplier,
    output reg  [10:0] clock_good_count,
    output reg         global_shutdown,
    output reg  [5:0]  clock_output_run,
    output reg  [5:0]  clock_output_oe,
    output reg  [5:0]  clock_output_level
);

    // stored register copies; reserved bits are never kept
    reg  [7:0]  mult_cfg1_q;
    reg  [7:0]  mult_cfg2_q;
    reg  [7:0]  mult_cfg3_q;
    reg  [7:0]  out_disable_q;
    reg  [6:0]  out_suspend_q;
    reg  [2:0]  pll_suspend_q;

    // combinational next values
    reg  [7:0]  rdata_d;
    reg         hit_d;
    reg  [7:0]  sel_byte;
    reg  [13:0] mult_d;
    reg  [5:0]  run_d;
    reg  [5:0]  oe_d;
    reg  [5:0]  level_d;
    reg  [5:0]  stopped;
    reg  [5:0]  suspended;
    reg  [1:0]  src;
    reg  [1:0]  style;

    // synchronised pins and what they decode to
    wire [1:0]  pins_sync;
    wire        shutdown_sync;
    wire        suspend_sync;
    wire        pin_active;
    wire        shutdown_d;
    wire        suspend_active;
    wire [2:0]  reg_sel;
    integer     i;

    // register slots from the shared address decode
    localparam [2:0] SLOT_CFG1    = 3'h0;
    localparam [2:0] SLOT_CFG2    = 3'h1;
    localparam [2:0] SLOT_CFG3    = 3'h2;
    localparam [2:0] SLOT_DISABLE = 3'h3;
    localparam [2:0] SLOT_SUSPEND = 3'h4;
    localparam [2:0] SLOT_PLL     = 3'h5;
    localparam [2:0] SLOT_NONE    = 3'h7;

    // reset values cut to the stored width; reserved bits are not kept
    localparam [7:0] SUSPEND_RST  = `OUT_SUSPEND_CTL_RST;
    localparam [7:0] PLL_SUSP_RST = `PLL_SUSPEND_CTL_RST;

    // total multiplier from one config byte and the low feedback bits
    function [13:0] total_mult;
        input [7:0] cfg_byte;
        input [7:0] fb_low;
        input       ss_en;
        reg   [11:0] fb;
        reg   [3:0]  frac;
        begin
            fb   = {cfg_byte[`FEEDBACK_HIGH_MSB:`FEEDBACK_HIGH_LSB], fb_low};
            frac = cfg_byte[`FRACTION_MSB:`FRACTION_LSB];
            if (frac == 4'h0 && !ss_en) begin
                total_mult = {1'b0, fb, 1'b0};
            end else begin
                // spread offset is added elsewhere, integer part only here
                total_mult = {1'b0, fb, 1'b0} + {10'h000, frac}
                             + 14'h0001;
            end
        end
    endfunction

    // park level for a stopped output, from its two-bit style field
    function [1:0] park_drive;
        input [1:0] sty;
        begin
            case (sty)
                `STYLE_PARK_LOW:  park_drive = 2'h1;
                `STYLE_PARK_HIGH: park_drive = 2'h3;
                default:          park_drive = 2'h0;
            endcase
        end
    endfunction

    // two-bit field of one output from a packed per-output vector
    function [1:0] out_field;
        input [11:0] vec;
        input integer idx;
        begin
            out_field = vec[2*idx +: 2];
        end
    endfunction

    // one address decode shared by the write and read paths
    function [2:0] reg_slot;
        input [7:0] addr;
        begin
            case (addr)
                `PLL0_MULT_CFG1_ADDR:  reg_slot = SLOT_CFG1;
                `PLL0_MULT_CFG2_ADDR:  reg_slot = SLOT_CFG2;
                `PLL0_MULT_CFG3_ADDR:  reg_slot = SLOT_CFG3;
                `OUT_DISABLE_CTL_ADDR: reg_slot = SLOT_DISABLE;
                `OUT_SUSPEND_CTL_ADDR: reg_slot = SLOT_SUSPEND;
                `PLL_SUSPEND_CTL_ADDR: reg_slot = SLOT_PLL;
                default:               reg_slot = SLOT_NONE;
            endcase
        end
    endfunction

    // shutdown/disable and suspend pins cross into the reference domain
    pin_sync u_pin_sync (
        .clk          (clk),
        .resetn       (resetn),
        .pin_async    ({suspend_input_pin, shutdown_pin}),
        .pin_sync_out (pins_sync)
    );

    // bit 0 carries the shutdown pin, bit 1 the suspend pin
    assign shutdown_sync = pins_sync[0];
    assign suspend_sync  = pins_sync[1];

    // polarity bit decides which pin level counts as asserted
    assign pin_active = out_disable_q[`POLARITY_BIT] ? ~shutdown_sync
                                                     : shutdown_sync;

    // function bit turns the pin into a global shutdown
    assign shutdown_d = out_disable_q[`FUNCTION_BIT] & pin_active;

    // suspend only means something while the pin is in suspend mode
    assign suspend_active = multi_function_pin_mode & suspend_sync;

    // one decode feeds both the write and the read path
    assign reg_sel = reg_slot(reg_addr);

    // register writes; reserved bits are not stored at all
    // a write lands on its edge, derived outputs follow one edge later
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mult_cfg1_q   <= `PLL0_MULT_CFG_RST;
            mult_cfg2_q   <= `PLL0_MULT_CFG_RST;
            mult_cfg3_q   <= `PLL0_MULT_CFG_RST;
            out_disable_q <= `OUT_DISABLE_CTL_RST;
            out_suspend_q <= SUSPEND_RST[6:0];
            pll_suspend_q <= PLL_SUSP_RST[`PLL_SUSP_MSB:`PLL_SUSP_LSB];
        end else if (reg_wr) begin
            case (reg_sel)
                SLOT_CFG1: begin
                    mult_cfg1_q <= reg_wdata;
                end
                SLOT_CFG2: begin
                    mult_cfg2_q <= reg_wdata;
                end
                SLOT_CFG3: begin
                    mult_cfg3_q <= reg_wdata;
                end
                SLOT_DISABLE: begin
                    out_disable_q <= reg_wdata;
                end
                SLOT_SUSPEND: begin
                    // bit 7 is reserved; software is expected to write zero
                    out_suspend_q <= reg_wdata[6:0];
                end
                SLOT_PLL: begin
                    pll_suspend_q <= reg_wdata[`PLL_SUSP_MSB:`PLL_SUSP_LSB];
                end
                default: begin
                    out_disable_q <= out_disable_q;
                end
            endcase
        end
    end

    // read decode; reserved bits come back as zero
    always @* begin
        rdata_d = 8'h00;
        hit_d   = 1'b1;
        case (reg_sel)
            SLOT_CFG1:    rdata_d = mult_cfg1_q;
            SLOT_CFG2:    rdata_d = mult_cfg2_q;
            SLOT_CFG3:    rdata_d = mult_cfg3_q;
            SLOT_DISABLE: rdata_d = out_disable_q;
            SLOT_SUSPEND: rdata_d = {1'b0, out_suspend_q};
            SLOT_PLL:     rdata_d = {5'h00, pll_suspend_q};
            default:      hit_d   = 1'b0;
        endcase
    end

    // read data is held until the next read strobe
    // holding it lets a slow serial decoder shift the byte out at leisure
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
            reg_hit   <= 1'b0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
            reg_hit   <= hit_d;
        end
    end

    // pick the multiplier byte of the active configuration slot
    always @* begin
        case (config_select)
            2'h0:    sel_byte = cfg0_multiplier_byte;
            2'h1:    sel_byte = mult_cfg1_q;
            2'h2:    sel_byte = mult_cfg2_q;
            2'h3:    sel_byte = mult_cfg3_q;
            default: sel_byte = cfg0_multiplier_byte;
        endcase
        // an illegal fraction is not trapped; the sum is just passed on
        mult_d = total_mult(sel_byte, feedback_low, spread_spectrum_en);
    end

    // per-output gating; shutdown wins over every select bit
    // a suspended output parks by its disable style, shutdown always floats
    always @* begin
        run_d     = 6'h00;
        oe_d      = 6'h00;
        level_d   = 6'h00;
        stopped   = 6'h00;
        suspended = 6'h00;
        src       = 2'h0;
        style     = 2'h0;
        for (i = 0; i < 6; i = i + 1) begin
            src   = out_field(output_pll_source, i);
            style = out_field(output_disable_style, i);
            // a pll select overrides the output's own suspend bit
            if (src != 2'h3 && pll_suspend_q[src]) begin
                suspended[i] = suspend_active;
            end else begin
                suspended[i] = suspend_active & out_suspend_q[i];
            end
            // the pin disables only outputs that opted in
            stopped[i] = (~out_disable_q[`FUNCTION_BIT] & pin_active
                          & out_disable_q[i])
                         | suspended[i];
            if (shutdown_d) begin
                // everything goes high impedance, selects are ignored
                run_d[i]   = 1'b0;
                oe_d[i]    = 1'b0;
                level_d[i] = 1'b0;
            end else if (stopped[i]) begin
                run_d[i]   = 1'b0;
                oe_d[i]    = park_drive(style) != 2'h0;
                level_d[i] = park_drive(style) == 2'h3;
            end else begin
                run_d[i]   = 1'b1;
                oe_d[i]    = 1'b1;
                level_d[i] = 1'b0;
            end
        end
    end

    // registered outputs keep gating edges free of decode glitches
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pll0_total_multiplier <= 14'h0000;
            clock_good_count      <= `CLOCK_GOOD_LONG;
            global_shutdown       <= 1'b0;
            clock_output_run      <= 6'h00;
            clock_output_oe       <= 6'h00;
            clock_output_level    <= 6'h00;
        end else begin
            pll0_total_multiplier <= mult_d;
            if (out_suspend_q[`CLOCK_GOOD_BIT]) begin
                clock_good_count <= `CLOCK_GOOD_LONG;
            end else begin
                clock_good_count <= `CLOCK_GOOD_SHORT;
            end
            global_shutdown    <= shutdown_d;
            clock_output_run   <= run_d;
            clock_output_oe    <= oe_d;
            clock_output_level <= level_d;
        end
    end

endmodule

`default_nettype wire

// ===== core/clkgen_defines.vh
// Contract
// - fraction zero, no spread: multiplier is twice feedback
// - fraction nonzero: twice feedback plus fraction plus one
// - polarity bit clear active high, set active low
// - function bit set means global shutdown pin
// - global shutdown overrides disable and suspend selects
// - disable select lets pin disable that output
// - suspend select suspends output on suspend pin
// - pll suspend select suspends all its outputs
// - pll suspend select overrides per-output suspend select
// - clock-good count clear eight, set 1024 cycles
// - disabled output tristates, parks low or high
`ifndef CLKGEN_DEFINES_VH
`define CLKGEN_DEFINES_VH

// register offsets
`define PLL0_MULT_CFG1_ADDR   8'h19
`define PLL0_MULT_CFG2_ADDR   8'h1a
`define PLL0_MULT_CFG3_ADDR   8'h1b
`define OUT_DISABLE_CTL_ADDR  8'h1c
`define OUT_SUSPEND_CTL_ADDR  8'h1d
`define PLL_SUSPEND_CTL_ADDR  8'h1e

// reset values
`define PLL0_MULT_CFG_RST     8'h00
`define OUT_DISABLE_CTL_RST   8'h00
`define OUT_SUSPEND_CTL_RST   8'h40
`define PLL_SUSPEND_CTL_RST   8'h00

// multiplier config fields
`define FRACTION_MSB          7
`define FRACTION_LSB          4
`define FEEDBACK_HIGH_MSB     3
`define FEEDBACK_HIGH_LSB     0

// output disable control fields
`define POLARITY_BIT          7
`define FUNCTION_BIT          6
`define DISABLE_SEL_MSB       5
`define DISABLE_SEL_LSB       0

// output suspend control fields
`define CLOCK_GOOD_BIT        6
`define SUSPEND_SEL_MSB       5
`define SUSPEND_SEL_LSB       0

// pll suspend control fields
`define PLL_SUSP_MSB          2
`define PLL_SUSP_LSB          0

// clock-good qualification counts, in input clock cycles
`define CLOCK_GOOD_SHORT      11'h008
`define CLOCK_GOOD_LONG       11'h400

// disable style encodings
`define STYLE_PARK_LOW        2'h2
`define STYLE_PARK_HIGH       2'h3

`endif

// ===== core/pin_sync.v
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser for the asynchronous control pins
module pin_sync (
    input  wire       clk,
    input  wire       resetn,
    input  wire [1:0] pin_async,
    output wire [1:0] pin_sync_out
);

    reg [1:0] stage1_q;
    reg [1:0] stage2_q;

    // first stage feeds only the second stage
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1_q <= 2'h0;
            stage2_q <= 2'h0;
        end else begin
            stage1_q <= pin_async;
            stage2_q <= stage1_q;
        end
    end

    assign pin_sync_out = stage2_q;

endmodule

`default_nettype wire

// ===== verification/output_gating_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// watches the register port and the gated clock outputs
module output_gating_asserts (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [7:0]  cfg0_multiplier_byte,
    input wire logic [7:0]  feedback_low,
    input wire logic [1:0]  config_select,
    input wire logic        spread_spectrum_en,
    input wire logic [11:0] output_disable_style,
    input wire logic        shutdown_pin,
    input wire logic [13:0] pll0_total_multiplier,
    input wire logic [10:0] clock_good_count,
    input wire logic        global_shutdown,
    input wire logic [5:0]  clock_output_run,
    input wire logic [5:0]  clock_output_oe,
    input wire logic [5:0]  clock_output_level
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [11:0] sty_q;
    logic [5:0]  park_bad;
    // style as the output flops saw it, so the check lines up in time
    always @(posedge clk or negedge resetn)
        if (!resetn)
            sty_q <= 12'h000;
        else
            sty_q <= output_disable_style;
    // a stopped pin follows its style unless a global shutdown holds it
    always_comb
        for (int i = 0; i < 6; i++)
            park_bad[i] = !clock_output_run[i] && (clock_output_oe[i] ?
                !sty_q[2*i+1] || clock_output_level[i] != sty_q[2*i] :
                sty_q[2*i+1] && !global_shutdown);
    a_mult_double: assert property (config_select == 2'h0 &&
        cfg0_multiplier_byte[7:4] == 4'h0 && !spread_spectrum_en
        |=> pll0_total_multiplier == {$past(cfg0_multiplier_byte[3:0]),
        $past(feedback_low), 1'b0}) else $error("multiplier not 2N");
    a_mult_frac: assert property (config_select == 2'h0 &&
        cfg0_multiplier_byte[7:4] != 4'h0 |=> pll0_total_multiplier ==
        {1'b0, $past(cfg0_multiplier_byte[3:0]), $past(feedback_low),
        1'b0} + $past(cfg0_multiplier_byte[7:4]) + 14'h0001)
        else $error("multiplier not 2N+A+1");
    a_shutdown_wins: assert property (global_shutdown |->
        clock_output_run == 6'h00 && clock_output_oe == 6'h00)
        else $error("output active during shutdown");
    a_good_count: assert property (reg_wr && reg_addr == 8'h1d
        |=> ##1 clock_good_count == ($past(reg_wdata[6], 2) ?
        11'h400 : 11'h008)) else $error("clock good count wrong");
    a_reserved_zero: assert property (reg_rd && (reg_addr == 8'h1d
        || reg_addr == 8'h1e) |=> !reg_rdata[7] &&
        (reg_rdata[6:3] == 4'h0 || $past(reg_addr) != 8'h1e))
        else $error("reserved bits read nonzero");
    a_park_style: assert property (park_bad == 6'h00)
        else $error("stopped output ignores its style");
    a_run_driven: assert property ((clock_output_run &
        ~clock_output_oe) == 6'h00) else $error("running pin undriven");
    a_pin_sync: assert property ($changed(global_shutdown) |->
        $past(shutdown_pin, 3) != $past(shutdown_pin, 4) ||
        $past(reg_wr, 2)) else $error("shutdown moved without sync");
endmodule
bind output_gating output_gating_asserts u_asserts (.clk, .resetn,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cfg0_multiplier_byte, .feedback_low, .config_select,
    .spread_spectrum_en, .output_disable_style, .shutdown_pin,
    .pll0_total_multiplier, .clock_good_count, .global_shutdown,
    .clock_output_run, .clock_output_oe, .clock_output_level);
`default_nettype wire

// ===== verification/output_gating_and_pll0_multiplier_test.sv
`timescale 1ns/100ps
`default_nettype none
// directed register and gating sequences, inputs moved at falling edges
module output_gating_and_pll0_multiplier_test;
    logic        clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [7:0]  cfg0_multiplier_byte = 8'h00, feedback_low = 8'h00;
    logic [1:0]  config_select = 2'h0;
    logic        spread_spectrum_en = 1'b0, multi_function_pin_mode = 1'b0;
    logic [11:0] output_pll_source = 12'h000, output_disable_style = 12'h000;
    logic        shutdown_pin = 1'b0, suspend_input_pin = 1'b0;
    logic        reg_hit, global_shutdown;
    logic [13:0] pll0_total_multiplier;
    logic [10:0] clock_good_count;
    logic [5:0]  clock_output_run, clock_output_oe, clock_output_level;
    int          num_errors = 0, checked = 0;
    output_gating DUT (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .reg_hit, .cfg0_multiplier_byte, .feedback_low,
        .config_select, .spread_spectrum_en, .output_pll_source,
        .output_disable_style, .multi_function_pin_mode, .shutdown_pin,
        .suspend_input_pin, .pll0_total_multiplier, .clock_good_count,
        .global_shutdown, .clock_output_run, .clock_output_oe,
        .clock_output_level);
    always #10 clk = ~clk;
    task chk(input string what, input logic [13:0] exp, got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // extra wait lets the stored byte reach the registered outputs
    task wr(input logic [7:0] a, d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // one idle edge after the strobe, so back-to-back reads never retoggle it
    task rd(input logic [7:0] a, exp, input logic hit);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        chk("reg_rdata", {6'h00, exp}, {6'h00, reg_rdata});
        chk("reg_hit", {13'h0000, hit}, {13'h0000, reg_hit});
    endtask
    task mult(input logic [7:0] c, f, input logic [1:0] s, input logic e,
              input logic [13:0] exp);
        cfg0_multiplier_byte = c;
        feedback_low = f;
        config_select = s;
        spread_spectrum_en = e;
        repeat (2) @(negedge clk);
        chk("multiplier", exp, pll0_total_multiplier);
    endtask
    // two sync stages plus the output flop, with one edge to spare
    task pins(input logic sd, su);
        shutdown_pin = sd;
        suspend_input_pin = su;
        repeat (4) @(negedge clk);
    endtask
    task outs(input logic [5:0] run, oe);
        chk("run", {8'h00, run}, {8'h00, clock_output_run});
        chk("oe", {8'h00, oe}, {8'h00, clock_output_oe});
    endtask
    task end_of_test;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // guards against a sequence that never returns
    initial begin
        #1000000;
        num_errors++;
        end_of_test;
    end
    initial begin
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        chk("good_count", 14'h0400, {3'h0, clock_good_count});
        for (int a = 8'h19; a < 8'h1d; a++)
            rd(8'(a), 8'h00, 1'b1);
        rd(8'h1d, 8'h40, 1'b1);
        rd(8'h1e, 8'h00, 1'b1);
        wr(8'h1f, 8'hff);
        rd(8'h1f, 8'h00, 1'b0);
        wr(8'h1d, 8'h7f);
        rd(8'h1d, 8'h7f, 1'b1);
        wr(8'h1e, 8'h07);
        rd(8'h1e, 8'h07, 1'b1);
        wr(8'h1e, 8'h00);
        wr(8'h1d, 8'h00);
        chk("good_count", 14'h0008, {3'h0, clock_good_count});
        wr(8'h1d, 8'h40);
        chk("good_count", 14'h0400, {3'h0, clock_good_count});
        $display("test registers done");
        mult(8'h01, 8'h23, 2'h0, 1'b0, 14'h0246);
        mult(8'h31, 8'h23, 2'h0, 1'b0, 14'h024a);
        mult(8'h01, 8'h23, 2'h0, 1'b1, 14'h0247);
        wr(8'h19, 8'h52);
        mult(8'h00, 8'h10, 2'h1, 1'b0, 14'h0426);
        wr(8'h1a, 8'h07);
        mult(8'h00, 8'hff, 2'h2, 1'b0, 14'h0ffe);
        wr(8'h1b, 8'hf0);
        mult(8'h00, 8'h11, 2'h3, 1'b0, 14'h0032);
        $display("test multiplier done");
        wr(8'h1c, 8'h01);
        pins(1'b1, 1'b0);
        outs(6'h3e, 6'h3e);
        output_disable_style = 12'h003;
        pins(1'b1, 1'b0);
        outs(6'h3e, 6'h3f);
        chk("level", 14'h0001, {13'h0000, clock_output_level[0]});
        output_disable_style = 12'h002;
        pins(1'b1, 1'b0);
        chk("level", 14'h0000, {13'h0000, clock_output_level[0]});
        output_disable_style = 12'h000;
        wr(8'h1c, 8'h81);
        outs(6'h3f, 6'h3f);
        pins(1'b0, 1'b0);
        outs(6'h3e, 6'h3e);
        output_disable_style = 12'hfff;
        wr(8'h1c, 8'hff);
        chk("shutdown", 14'h0001, {13'h0000, global_shutdown});
        outs(6'h00, 6'h00);
        pins(1'b1, 1'b0);
        outs(6'h3f, 6'h3f);
        output_disable_style = 12'h000;
        wr(8'h1c, 8'h00);
        $display("test disable done");
        multi_function_pin_mode = 1'b1;
        wr(8'h1d, 8'h42);
        pins(1'b0, 1'b1);
        outs(6'h3d, 6'h3d);
        multi_function_pin_mode = 1'b0;
        pins(1'b0, 1'b1);
        outs(6'h3f, 6'h3f);
        multi_function_pin_mode = 1'b1;
        output_pll_source = 12'hd40;
        wr(8'h1d, 8'h48);
        wr(8'h1e, 8'h01);
        outs(6'h30, 6'h30);
        wr(8'h1c, 8'h40);
        pins(1'b1, 1'b1);
        outs(6'h00, 6'h00);
        $display("test suspend done");
        end_of_test;
    end
endmodule
`default_nettype wire
